// File: src/smsp_top.sv
// serial host port and alert logic of a 24-input switch monitor
//
// Overview of operation
// RULE1: shifting happens only while chip select is low, the serial clock is ignored otherwise.
// RULE2: with chip select low the input bit is captured on each falling serial clock edge.
// RULE3: with chip select low the next output bit is driven on each rising serial clock edge.
// RULE4: the serial output is released to high impedance while chip select is high.
// RULE5: the shifted word takes effect only on the rising edge of chip select.
// RULE6: devices chain by feeding serial output to the next serial input, bits pass through each register.
// RULE7: the open-drain alert pulls low when an enabled switch input changes state.
// RULE8: the alert is also pulled low on over-temperature regardless of the enables.
// RULE9: above the supply limit the wetting current is off and the inputs are not monitored.
// RULE10: after the supply returns a 1 ms blanking interval precedes resumed polling.
// RULE11: after leaving shutdown normal operation resumes within 1 ms, typically 0.1 ms.
// RULE12: polling period and active time stay within 20 percent of their programmed values.
// RULE13: the controller drives shutdown low to stop and high to run.
// RULE14: each input has its own alert enable written serially, all disabled after reset.
// RULE15: switch transitions are deglitched for about 50 us before counting as a change.
// RULE16: the master changes its data on rising edges so it is stable at falling edges.
`include "smsp_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module smsp_top (
    input wire logic clk, // 100 MHz system clock
    input wire logic reset, // synchronous, active high
    input wire logic sclk, // serial clock pin
    input wire logic cs_n, // chip select pin, active low
    input wire logic sdi, // serial data in pin
    output logic sdo_o, // serial data out value
    output logic sdo_oe, // serial data out enable
    input wire logic shutdown_n, // shutdown pin, low stops the block
    input wire logic over_voltage, // battery_supply above limit comparator
    input wire logic over_temp, // over-temperature comparator
    input wire logic [23:0] switch_inputs, // switch comparator levels
    output logic alert_o, // alert pin value, always low
    output logic alert_oe, // alert pin pulls low while high
    output logic wetting_en, // wetting current source enable
    output logic poll_active, // polling active window
    output logic [23:0] switch_state, // deglitched switch levels
    output logic word_valid, // captured word available
    input wire logic word_ready, // sink takes captured word
    output logic [47:0] word_data // captured word
);
    // ==========================================================
    // pin synchronisers
    logic [1:0] sclk_s_r, sclk_s_nxt, cs_s_r, cs_s_nxt, sdi_s_r, sdi_s_nxt, sd_s_r, sd_s_nxt;
    logic [1:0] ov_s_r, ov_s_nxt, ot_s_r, ot_s_nxt;
    logic [23:0] sw_m_r, sw_m_nxt, sw_s_r, sw_s_nxt;
    logic sclk_d_r, sclk_d_nxt, cs_d_r, cs_d_nxt;
    // two flip-flops on every pin, then one history stage for edges
    always_comb begin
        sclk_s_nxt = {sclk_s_r[0], sclk};
        cs_s_nxt = {cs_s_r[0], cs_n};
        sdi_s_nxt = {sdi_s_r[0], sdi};
        sd_s_nxt = {sd_s_r[0], shutdown_n};
        ov_s_nxt = {ov_s_r[0], over_voltage};
        ot_s_nxt = {ot_s_r[0], over_temp};
        sw_m_nxt = switch_inputs;
        sw_s_nxt = sw_m_r;
        sclk_d_nxt = sclk_s_r[1];
        cs_d_nxt = cs_s_r[1];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sclk_s_r <= 2'h0;
            cs_s_r <= 2'h3;
            sdi_s_r <= 2'h0;
            sd_s_r <= 2'h0;
            ov_s_r <= 2'h0;
            ot_s_r <= 2'h0;
            sw_m_r <= 24'h000000;
            sw_s_r <= 24'h000000;
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
        end else begin
            sclk_s_r <= sclk_s_nxt;
            cs_s_r <= cs_s_nxt;
            sdi_s_r <= sdi_s_nxt;
            sd_s_r <= sd_s_nxt;
            ov_s_r <= ov_s_nxt;
            ot_s_r <= ot_s_nxt;
            sw_m_r <= sw_m_nxt;
            sw_s_r <= sw_s_nxt;
            sclk_d_r <= sclk_d_nxt;
            cs_d_r <= cs_d_nxt;
        end
    end

    logic cs_low, sclk_rise, sclk_fall, cs_rise, over_temp_s;
    assign over_temp_s = ot_s_r[1]; // synced over-temperature level
    assign cs_low = ~cs_s_r[1];
    assign sclk_rise = sclk_s_r[1] & ~sclk_d_r;
    assign sclk_fall = ~sclk_s_r[1] & sclk_d_r;
    assign cs_rise = cs_s_r[1] & ~cs_d_r;

    // ==========================================================
    // serial shift register
    logic [47:0] shift_r, shift_nxt, status_r, status_nxt;
    logic sdo_r, sdo_nxt, load_r, load_nxt;
    logic buf_in_ready;
    // load status at frame start, then shift; msb goes out first
    always_comb begin
        shift_nxt = shift_r;
        sdo_nxt = sdo_r;
        load_nxt = load_r;
        status_nxt = status_r;
        if (!cs_low) begin
            load_nxt = 1'b1;
        // RULE1: shift only inside a frame
        end else if (load_r) begin
            shift_nxt = status_r;
            sdo_nxt = status_r[`SMSP_WORD_MSB];
            load_nxt = 1'b0;
        // RULE2: sample on falling edge
        end else if (sclk_fall) begin
            // RULE6: bits pass straight through for chaining
            shift_nxt = {shift_r[`SMSP_WORD_MSB-1:0], sdi_s_r[1]};
        // RULE3: next bit out on rising edge
        end else if (sclk_rise) begin
            sdo_nxt = shift_r[`SMSP_WORD_MSB];
        end
        if (!cs_low) begin
            status_nxt = {switch_state, 23'h000000, over_temp_s};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            shift_r <= 48'h000000000000;
            sdo_r <= 1'b0;
            load_r <= 1'b1;
            status_r <= 48'h000000000000;
        end else begin
            shift_r <= shift_nxt;
            sdo_r <= sdo_nxt;
            load_r <= load_nxt;
            status_r <= status_nxt;
        end
    end

    // RULE4: release the line outside a frame
    assign sdo_o = sdo_r;
    assign sdo_oe = cs_low;

    // ==========================================================
    // two-entry word buffer
    smsp_pkg::smsp_word_s buf_r [2];
    smsp_pkg::smsp_word_s buf_nxt [2];
    logic [1:0] cnt_r, cnt_nxt;
    logic push, pop;
    // RULE5: word committed on chip select rising edge
    assign push = cs_rise & buf_in_ready;
    assign pop = word_valid & word_ready;
    assign buf_in_ready = (cnt_r != 2'h2);
    assign word_valid = (cnt_r != 2'h0);
    assign word_data = buf_r[0];

    // queue in slot order; a pop shifts slot 1 down
    always_comb begin
        buf_nxt[0] = buf_r[0];
        buf_nxt[1] = buf_r[1];
        cnt_nxt = cnt_r;
        if (pop) begin
            buf_nxt[0] = buf_r[1];
            cnt_nxt = cnt_r - 2'h1;
        end
        if (push) begin
            buf_nxt[cnt_nxt[0]] = shift_r;
            cnt_nxt = cnt_nxt + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            buf_r[0] <= 48'h000000000000;
            buf_r[1] <= 48'h000000000000;
            cnt_r <= 2'h0;
        end else begin
            buf_r[0] <= buf_nxt[0];
            buf_r[1] <= buf_nxt[1];
            cnt_r <= cnt_nxt;
        end
    end

    // ==========================================================
    // alert enables
    logic [23:0] enables_r, enables_nxt;
    // RULE14: enables load from each committed word, cleared at reset
    always_comb begin
        enables_nxt = enables_r;
        if (push) begin
            enables_nxt = shift_r[`SMSP_WORD_MSB -: `SMSP_NCH];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            enables_r <= `SMSP_ENABLE_RST;
        end else begin
            enables_r <= enables_nxt;
        end
    end

    // ==========================================================
    // operating mode and polling timers
    smsp_pkg::smsp_mode_e mode_r, mode_nxt;
    logic [31:0] tmr_r, tmr_nxt, poll_r, poll_nxt;
    logic monitoring;
    // startup and blanking delays, then run
    always_comb begin
        mode_nxt = mode_r;
        tmr_nxt = tmr_r + 32'h1;
        // RULE13: shutdown pin low stops the block
        if (!sd_s_r[1]) begin
            mode_nxt = smsp_pkg::SMSP_OFF;
            tmr_nxt = 32'h0;
        // RULE9: supply over limit stops monitoring
        end else if (ov_s_r[1]) begin
            mode_nxt = smsp_pkg::SMSP_BLANKING;
            tmr_nxt = 32'h0;
        end else begin
            case (mode_r)
                smsp_pkg::SMSP_OFF: begin
                    mode_nxt = smsp_pkg::SMSP_STARTING;
                    tmr_nxt = 32'h0;
                end
                // RULE11: resume after typical start delay
                smsp_pkg::SMSP_STARTING: begin
                    if (tmr_r >= 32'(`SMSP_START_CYC - 1)) begin
                        mode_nxt = smsp_pkg::SMSP_RUN;
                        tmr_nxt = 32'h0;
                    end
                end
                // RULE10: blanking before polling resumes
                smsp_pkg::SMSP_BLANKING: begin
                    if (tmr_r >= 32'(`SMSP_BLANK_CYC - 1)) begin
                        mode_nxt = smsp_pkg::SMSP_RUN;
                        tmr_nxt = 32'h0;
                    end
                end
                default: begin
                    tmr_nxt = 32'h0;
                end
            endcase
        end
    end

    // RULE12: exact crystal-derived counts sit well inside tolerance
    always_comb begin
        poll_nxt = 32'h0;
        if (mode_r == smsp_pkg::SMSP_RUN && poll_r < `SMSP_POLL_PERIOD_CYC - 32'h1) begin
            poll_nxt = poll_r + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_r <= smsp_pkg::SMSP_OFF;
            tmr_r <= 32'h0;
            poll_r <= 32'h0;
        end else begin
            mode_r <= mode_nxt;
            tmr_r <= tmr_nxt;
            poll_r <= poll_nxt;
        end
    end

    assign monitoring = (mode_r == smsp_pkg::SMSP_RUN);
    assign poll_active = monitoring && (poll_r < `SMSP_POLL_ACT_CYC);
    assign wetting_en = poll_active;

    // ==========================================================
    // deglitch and change detect, one filter per channel
    logic [23:0] change;
    genvar g;
    generate
        for (g = 0; g < `SMSP_NCH; g = g + 1) begin : g_ch
            logic [12:0] flt_r, flt_nxt;
            logic st_r, st_nxt, chg;
            // RULE15: level must hold for the filter time
            always_comb begin
                flt_nxt = 13'h0;
                st_nxt = st_r;
                chg = 1'b0;
                if (monitoring && sw_s_r[g] != st_r) begin
                    flt_nxt = flt_r + 13'h1;
                    if (flt_r >= 13'(`SMSP_DEGLITCH_CYC - 1)) begin
                        st_nxt = sw_s_r[g];
                        flt_nxt = 13'h0;
                        chg = 1'b1;
                    end
                end
            end
            always_ff @(posedge clk) begin
                if (reset) begin
                    flt_r <= 13'h0;
                    st_r <= 1'b0;
                end else begin
                    flt_r <= flt_nxt;
                    st_r <= st_nxt;
                end
            end
            assign switch_state[g] = st_r;
            assign change[g] = chg;
        end
    endgenerate

    // ==========================================================
    // alert latch
    logic pend_r, pend_nxt;
    // RULE7: enabled change latches the alert, set wins over the clear
    always_comb begin
        pend_nxt = pend_r;
        if (push) begin
            pend_nxt = 1'b0;
        end
        if (|(change & enables_r)) begin
            pend_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pend_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    // RULE8: over-temperature pulls the alert regardless of enables
    assign alert_oe = pend_r | over_temp_s;
    assign alert_o = 1'b0;
endmodule : smsp_top

`default_nettype wire

// File: src/smsp_consts.svh
// timing counts and widths for the switch monitor serial port
`ifndef SMSP_CONSTS_SVH
`define SMSP_CONSTS_SVH
`define SMSP_CLK_NS 10
`define SMSP_NCH 24
`define SMSP_WORD_BITS 48
`define SMSP_WORD_MSB 47
`define SMSP_DEGLITCH_NOM_US 50
`define SMSP_DEGLITCH_CYC ((`SMSP_DEGLITCH_NOM_US * 1000) / `SMSP_CLK_NS)
`define SMSP_BLANK_MS 1
`define SMSP_BLANK_CYC ((`SMSP_BLANK_MS * 1000000) / `SMSP_CLK_NS)
`define SMSP_START_TYP_US 100
`define SMSP_START_CYC ((`SMSP_START_TYP_US * 1000) / `SMSP_CLK_NS)
`define SMSP_POLL_PERIOD_CYC 32'd6400000
`define SMSP_POLL_ACT_CYC 32'd100000
`define SMSP_CTR_W 32
`define SMSP_ENABLE_RST 24'h000000
`endif

// File: src/smsp_pkg.sv
// types shared by the switch monitor serial port
package smsp_pkg;
    typedef enum logic [1:0] {
        SMSP_OFF,
        SMSP_STARTING,
        SMSP_BLANKING,
        SMSP_RUN
    } smsp_mode_e;

    // word handed from the serial side to the configuration side
    typedef struct packed {
        logic [23:0] enables;
        logic [23:0] spare;
    } smsp_word_s;
endpackage : smsp_pkg

// File: tb/smsp_checker.sv
// assertions on the switch monitor serial port pins
`timescale 1ns/100ps
`default_nettype none
module smsp_checker (
    input wire logic clk, // clock
    input wire logic reset, // sync reset
    input wire logic sclk, // serial clock
    input wire logic cs_n, // chip select
    input wire logic sdo_o, // out value
    input wire logic sdo_oe, // out enable
    input wire logic shutdown_n, // shutdown pin
    input wire logic over_voltage, // supply high
    input wire logic over_temp, // too hot
    input wire logic alert_o, // alert value
    input wire logic alert_oe, // alert pull
    input wire logic wetting_en, // wetting on
    input wire logic poll_active, // poll window
    input wire logic word_valid, // word held
    input wire logic word_ready, // word taken
    input wire logic [47:0] word_data // word
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // ========================================
    // sequences and properties
    sequence s_idle;
        cs_n [*4];
    endsequence
    sequence s_off;
        !shutdown_n [*4];
    endsequence
    a_oe_released:
    assert property (s_idle |-> !sdo_oe) else $error("sdo driven while deselected");
    a_oe_driven:
    assert property ($fell(cs_n) |-> ##[1:4] sdo_oe) else $error("sdo not driven");
    a_out_on_rise:
    assert property (sdo_oe && $past(sdo_oe) && $past(sdo_oe, 2) && $changed(sdo_o) |-> $past(sclk, 2))
        else $error("sdo moved off rise");
    a_commit_only:
    assert property ($rose(word_valid) |-> $past(cs_n) && $past(cs_n, 3)) else $error("word without commit");
    a_word_held:
    assert property (word_valid && !word_ready |=> word_valid && $stable(word_data)) else $error("word lost");
    a_temp_alert:
    assert property (over_temp [*3] |-> alert_oe) else $error("no alert when hot");
    a_alert_low:
    assert property (alert_oe |-> !alert_o) else $error("alert not low");
    a_ov_dark:
    assert property (over_voltage [*4] |-> !wetting_en && !poll_active) else $error("active in overvoltage");
    a_blank_quiet:
    assert property ($fell(over_voltage) |-> !poll_active [*8]) else $error("poll in blanking");
    a_sd_off:
    assert property (s_off |-> !wetting_en && !poll_active) else $error("active in shutdown");
endmodule : smsp_checker
bind smsp_top smsp_checker chk (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdo_o(sdo_o),
    .sdo_oe(sdo_oe), .shutdown_n(shutdown_n), .over_voltage(over_voltage), .over_temp(over_temp),
    .alert_o(alert_o), .alert_oe(alert_oe), .wetting_en(wetting_en), .poll_active(poll_active),
    .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));
`default_nettype wire

// File: tb/smsp_host_model.sv
// serial master model for the monitor port
`timescale 1ns/100ps
`default_nettype none
module smsp_host_model (
    input wire logic clk, // system clock
    output logic sclk, // serial clock
    output logic cs_n, // chip select
    output logic sdi, // data to device
    input wire logic sdo // data from device
);
    logic [47:0] rx;
    // idle pins, sdi rests at its pull-down level
    initial begin
        sclk = 0;
        cs_n = 1;
        sdi = 0;
        rx = 48'h0;
    end
    // ========================================
    // one frame, msb first, sel low leaves chip unselected
    // data changes on rise, sampled on fall
    task automatic xfer(input logic [95:0] tx, input int nbits, input logic sel);
        cs_n = !sel;
        repeat (6) @(negedge clk);
        for (int i = nbits - 1; i >= 0; i--) begin
            sclk = 1;
            sdi = tx[i];
            repeat (5) @(negedge clk);
            sclk = 0;
            rx = {rx[46:0], sdo};
            repeat (5) @(negedge clk);
        end
        cs_n = 1;
        sdi = 0;
        repeat (8) @(negedge clk);
    endtask : xfer
endmodule : smsp_host_model
`default_nettype wire

// File: tb/smsp_top_bench.sv
// self-checking bench for the monitor serial port
`timescale 1ns/100ps
`default_nettype none
module smsp_top_bench;
    logic clk, reset, shutdown_n, over_voltage, over_temp, word_ready;
    logic sclk, cs_n, sdi, sdo_o, sdo_oe, alert_o, alert_oe, wetting_en, poll_active, word_valid;
    logic [23:0] switch_inputs;
    logic [23:0] switch_state;
    logic [47:0] word_data;
    wire logic sdo_w = sdo_oe ? sdo_o : 1'bz;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    // ========================================
    // clock and hang guard
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            complete_run();
        end
    end
    smsp_top DUT (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_o(sdo_o),
        .sdo_oe(sdo_oe), .shutdown_n(shutdown_n), .over_voltage(over_voltage), .over_temp(over_temp),
        .switch_inputs(switch_inputs), .alert_o(alert_o), .alert_oe(alert_oe), .wetting_en(wetting_en),
        .poll_active(poll_active), .switch_state(switch_state), .word_valid(word_valid),
        .word_ready(word_ready), .word_data(word_data));
    smsp_host_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_w));
    // ========================================
    // compare, take a word, finish
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic pop(input logic [47:0] exp);
        check("word_valid", word_valid, 1'b1);
        check("word_data", word_data, exp);
        word_ready = 1;
        @(negedge clk);
        word_ready = 0;
        @(negedge clk);
    endtask : pop
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    // ========================================
    // scenarios
    task automatic test_frame();
        over_temp = 1;
        repeat (4) @(negedge clk);
        host.xfer({48'h0, 24'h000001, 24'h0}, 48, 1);
        check("status", host.rx, 48'h1);
        check("alert_oe", alert_oe, 1'b1);
        over_temp = 0;
        repeat (4) @(negedge clk);
        check("alert_oe", alert_oe, 1'b0);
        pop(48'h000001000000);
        $display("frame test done");
    endtask : test_frame
    task automatic test_alert();
        repeat (11000) @(negedge clk);
        switch_inputs[1] = 1;
        repeat (6000) @(negedge clk);
        check("alert_oe", alert_oe, 1'b0);
        switch_inputs[0] = 1;
        repeat (3000) @(negedge clk);
        check("switch_state", switch_state, 24'h000002);
        repeat (3000) @(negedge clk);
        check("alert_oe", alert_oe, 1'b1);
        host.xfer({48'h0, 24'h000001, 24'h0}, 48, 1);
        check("status", host.rx, 48'h000003000000);
        pop(48'h000001000000);
        check("alert_oe", alert_oe, 1'b0);
        $display("alert test done");
    endtask : test_alert
    task automatic test_chain();
        host.xfer(96'h123456789abc_fedcba987654, 96, 1);
        check("passed", host.rx, 48'h123456789abc);
        pop(48'hfedcba987654);
        $display("chain test done");
    endtask : test_chain
    task automatic test_buffer();
        host.xfer(96'h5, 48, 0);
        check("word_valid", word_valid, 1'b0);
        for (int k = 1; k <= 3; k++) begin
            host.xfer(96'(k), 48, 1);
        end
        pop(48'h1);
        pop(48'h2);
        check("word_valid", word_valid, 1'b0);
        $display("buffer test done");
    endtask : test_buffer
    task automatic test_supply();
        check("poll_active", poll_active, 1'b1);
        shutdown_n = 0;
        repeat (6) @(negedge clk);
        check("wetting_en", wetting_en, 1'b0);
        shutdown_n = 1;
        repeat (500) @(negedge clk);
        check("poll_active", poll_active, 1'b0);
        repeat (10000) @(negedge clk);
        check("poll_active", poll_active, 1'b1);
        over_voltage = 1;
        repeat (6) @(negedge clk);
        check("wetting_en", wetting_en, 1'b0);
        over_voltage = 0;
        repeat (500) @(negedge clk);
        check("poll_active", poll_active, 1'b0);
        $display("supply test done");
    endtask : test_supply
    // ========================================
    // main sequence
    initial begin
        reset = 1;
        shutdown_n = 1;
        over_voltage = 0;
        over_temp = 0;
        word_ready = 0;
        switch_inputs = 24'h000000;
        repeat (3) @(negedge clk);
        reset = 0;
        repeat (4) @(negedge clk);
        check("sdo_oe", sdo_oe, 1'b0);
        check("alert_oe", alert_oe, 1'b0);
        test_frame();
        test_alert();
        test_chain();
        test_buffer();
        test_supply();
        complete_run();
    end
endmodule : smsp_top_bench
`default_nettype wire
